// ===== ddc_pkg.sv
/*
 * Package for the downconverter channel three decimation rate select block:
 * register offsets, field positions, select codes, stage masks and ratios.
 * Assumes a 32-bit Avalon-MM slave with byte addresses, word aligned.
 */
// Functional notes
// RULE1 - primary all-ones defers to secondary upper nibble
// RULE2 - secondary field ignored unless primary equals 111
// RULE3 - secondary 000: third-band two, four half-bands, 48/24
// RULE4 - fifth-band two plus half-band one: 10/5
// RULE5 - fifth-band two plus half-bands two, one: 20/10
// RULE6 - fifth-band two plus half-bands three..one: 40 disabled
// RULE7 - primary half-bands one..three plus third-band: 24/12
// RULE8 - primary half-bands one, two plus third-band: 6 enabled
// RULE9 - secondary 010 selects fifth-band two, half-band one
// RULE10 - secondary 011 selects fifth-band two, half-bands two, one
// RULE11 - undocumented secondary codes keep chain unchanged
package ddc_pkg;
   // register indices; the byte address is four times the index
   localparam logic [11:0] PRIMARY_SELECT_IDX = 12'h310;
   localparam logic [11:0] SECONDARY_SELECT_IDX = 12'h371;
   localparam logic [13:0] PRIMARY_SELECT_ADDR = {PRIMARY_SELECT_IDX, 2'b00};
   localparam logic [13:0] SECONDARY_SELECT_ADDR = {SECONDARY_SELECT_IDX, 2'b00};
   localparam logic [13:0] STATUS_ADDR = 14'h0D00;
   localparam int ADDR_W = 14;

   // field positions
   localparam int PRI_SEL_LSB = 0;
   localparam int PRI_C2R_BIT = 3;
   localparam int SEC_SEL_LSB = 4;
   localparam int SEL_W = 3;

   // reset values
   localparam logic [7:0] PRIMARY_RESET = 8'h00;
   localparam logic [7:0] SECONDARY_RESET = 8'h00;

   // select codes
   localparam logic [2:0] PRI_HALF1 = 3'h3;
   localparam logic [2:0] PRI_HALF1_THIRD = 3'h4;
   localparam logic [2:0] PRI_HALF12_THIRD = 3'h5;
   localparam logic [2:0] PRI_HALF123_THIRD = 3'h6;
   localparam logic [2:0] PRI_DEFER = 3'h7;
   localparam logic [2:0] SEC_THIRD_HALF4321 = 3'h0;
   localparam logic [2:0] SEC_FIFTH_HALF1 = 3'h2;
   localparam logic [2:0] SEC_FIFTH_HALF21 = 3'h3;
   localparam logic [2:0] SEC_FIFTH_HALF321 = 3'h4;

   // stage mask bits: [0] hb one .. [3] hb four, [4] third two, [5] fifth two
   localparam logic [5:0] STG_HALF1 = 6'h01;
   localparam logic [5:0] STG_HALF1_THIRD = 6'h11;
   localparam logic [5:0] STG_HALF12_THIRD = 6'h13;
   localparam logic [5:0] STG_HALF123_THIRD = 6'h17;
   localparam logic [5:0] STG_THIRD_HALF4321 = 6'h1F;
   localparam logic [5:0] STG_FIFTH_HALF1 = 6'h21;
   localparam logic [5:0] STG_FIFTH_HALF21 = 6'h23;
   localparam logic [5:0] STG_FIFTH_HALF321 = 6'h27;

   // ratios with complex-to-real enabled; disabled doubles them
   localparam logic [6:0] RATIO_HALF1 = 7'h01;
   localparam logic [6:0] RATIO_HALF1_THIRD = 7'h03;
   localparam logic [6:0] RATIO_HALF12_THIRD = 7'h06;
   localparam logic [6:0] RATIO_HALF123_THIRD = 7'h0C;
   localparam logic [6:0] RATIO_THIRD_HALF4321 = 7'h18;
   localparam logic [6:0] RATIO_FIFTH_HALF1 = 7'h05;
   localparam logic [6:0] RATIO_FIFTH_HALF21 = 7'h0A;
   localparam logic [6:0] RATIO_FIFTH_HALF321 = 7'h14;

   localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
endpackage : ddc_pkg

// ===== ddc_rate_select.sv
/*
 * Decimation rate select for downconverter channel three: holds the
 * primary and secondary select registers and decodes the stage cascade
 * and overall ratio for the filter chain that sits outside this block.
 * The primary register carries a three-bit select and the complex-to-real
 * enable; its all-ones code hands the choice to the secondary field,
 * whose undocumented codes leave the chain as it stands.
 * Register map (byte addresses): primary at 0xC40, secondary at 0xDC4,
 * a read-only status word at 0xD00 with ratio, stage mask and the
 * conversion bit; other offsets read zero and ignore writes.
 * Outputs are registered, so a new setting reaches the chain one edge
 * after the write is acknowledged and the chain sees one clean change.
 * Limitation: only byte lane 0 is decoded; the upper lanes carry nothing.
 * Assumes an Avalon-MM master that holds its request until waitrequest
 * is sampled low, one clock, and a reset shared with the register map.
 * The filter datapath, input selection and other channels lie outside.
 */
`timescale 1ns/1ps
module ddc_rate_select (
   // clock and reset
   input wire logic sys_clk_in,
   input wire logic rst_b_in,
   // avalon-mm slave
   input wire logic [ddc_pkg::ADDR_W-1:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic [3:0] avs_byteenable_in,
   output logic [31:0] avs_readdata_out,
   output logic avs_waitrequest_out,
   // filter chain configuration
   output logic [5:0] stage_enable_out,
   output logic [6:0] decimation_ratio_out,
   output logic complex_to_real_out
);
   import ddc_pkg::*;

   // register storage
   logic [7:0] primary_select;
   logic [7:0] secondary_select;
   // bus handshake state
   logic acked;
   logic pri_write_hit;
   logic sec_write_hit;
   // field views of the stored registers
   logic [2:0] pri_code;
   logic [2:0] sec_code;
   logic c2r;
   // per-field decode results
   logic [5:0] pri_stage;
   logic [6:0] pri_ratio;
   logic pri_valid;
   logic [5:0] sec_stage;
   logic [6:0] sec_ratio;
   logic sec_valid;
   // selected cascade, ahead of the output registers
   logic [5:0] next_stage;
   logic [6:0] next_ratio;
   logic next_valid;

   // field views
   assign pri_code = primary_select[PRI_SEL_LSB +: SEL_W];
   assign sec_code = secondary_select[SEC_SEL_LSB +: SEL_W];
   assign c2r = primary_select[PRI_C2R_BIT];

   // writes land only on the acknowledging edge and only with lane 0 set;
   // upper lanes carry nothing, so their enables are ignored
   assign pri_write_hit = avs_write_in && acked && avs_byteenable_in[0]
      && (avs_address_in == PRIMARY_SELECT_ADDR);
   assign sec_write_hit = avs_write_in && acked && avs_byteenable_in[0]
      && (avs_address_in == SECONDARY_SELECT_ADDR);

   // one wait cycle per access keeps readdata registered
   // acked marks the answering cycle; a request held past it is seen as
   // a new access, so the master must release on the answering edge
   // trade-off: every access costs two cycles, reads and writes alike
   always_ff @(posedge sys_clk_in) begin
      if (!rst_b_in) begin
         acked <= 1'b0;
      end else begin
         acked <= (avs_read_in || avs_write_in) && !acked;
      end
   end

   // waitrequest idles high and drops for exactly the answering cycle;
   // it is registered so the master never sees a combinational path
   // from its own request back to the answer
   always_ff @(posedge sys_clk_in) begin
      if (!rst_b_in) begin
         avs_waitrequest_out <= 1'b1;
      end else begin
         avs_waitrequest_out <= !((avs_read_in || avs_write_in) && !acked);
      end
   end

   // register writes take effect on the acknowledging edge
   // the full byte is stored even for reserved codes, so readback
   // always shows what software wrote
   always_ff @(posedge sys_clk_in) begin
      if (!rst_b_in) begin
         primary_select <= PRIMARY_RESET;
         secondary_select <= SECONDARY_RESET;
      end else begin
         if (pri_write_hit) begin
            primary_select <= avs_writedata_in[7:0];
         end
         // reserved codes are kept as written; the decode ignores them
         if (sec_write_hit) begin // [RULE11]
            secondary_select <= avs_writedata_in[7:0];
         end
      end
   end

   // read data, unmapped offsets read zero
   // captured when the access is taken, so it stands at the answering edge
   // and holds until the next read
   always_ff @(posedge sys_clk_in) begin
      if (!rst_b_in) begin
         avs_readdata_out <= UNMAPPED_READ;
      end else if (avs_read_in && !acked) begin
         unique case (avs_address_in)
            PRIMARY_SELECT_ADDR: avs_readdata_out <= {24'h000000, primary_select};
            SECONDARY_SELECT_ADDR: avs_readdata_out <= {24'h000000, secondary_select};
            STATUS_ADDR: avs_readdata_out <= {17'h00000, complex_to_real_out,
               stage_enable_out, 1'b0, decimation_ratio_out};
            default: avs_readdata_out <= UNMAPPED_READ;
         endcase
      end
   end

   // secondary field decode; c2r halves the ratio so base is the enabled figure
   always_comb begin
      sec_stage = STG_HALF1;
      sec_ratio = RATIO_HALF1;
      sec_valid = 1'b1;
      unique case (sec_code)
         // third-band two ahead of all four half-bands
         SEC_THIRD_HALF4321: begin // [RULE3]
            sec_stage = STG_THIRD_HALF4321;
            sec_ratio = RATIO_THIRD_HALF4321;
         end
         // fifth-band two ahead of half-band one
         SEC_FIFTH_HALF1: begin // [RULE4] [RULE9]
            sec_stage = STG_FIFTH_HALF1;
            sec_ratio = RATIO_FIFTH_HALF1;
         end
         // fifth-band two ahead of half-bands two and one
         SEC_FIFTH_HALF21: begin // [RULE5] [RULE10]
            sec_stage = STG_FIFTH_HALF21;
            sec_ratio = RATIO_FIFTH_HALF21;
         end
         // fifth-band two ahead of half-bands three to one
         SEC_FIFTH_HALF321: begin // [RULE6]
            sec_stage = STG_FIFTH_HALF321;
            sec_ratio = RATIO_FIFTH_HALF321;
         end
         // codes 1, 5, 6 and 7 are reserved
         default: sec_valid = 1'b0; // [RULE11]
      endcase
   end

   // primary field decode; codes below the half-band-one code are not used
   // by this channel and hold the chain like a reserved code
   always_comb begin
      pri_stage = STG_HALF1;
      pri_ratio = RATIO_HALF1;
      pri_valid = 1'b1;
      unique case (pri_code)
         // half-band one alone
         PRI_HALF1: begin
            pri_stage = STG_HALF1;
            pri_ratio = RATIO_HALF1;
         end
         // half-band one and third-band two
         PRI_HALF1_THIRD: begin
            pri_stage = STG_HALF1_THIRD;
            pri_ratio = RATIO_HALF1_THIRD;
         end
         // half-bands one, two and third-band two
         PRI_HALF12_THIRD: begin // [RULE8]
            pri_stage = STG_HALF12_THIRD;
            pri_ratio = RATIO_HALF12_THIRD;
         end
         // half-bands one to three and third-band two
         PRI_HALF123_THIRD: begin // [RULE7]
            pri_stage = STG_HALF123_THIRD;
            pri_ratio = RATIO_HALF123_THIRD;
         end
         // the deferred code is resolved by the select below
         default: pri_valid = 1'b0;
      endcase
   end

   // the all-ones primary code hands the choice to the secondary field;
   // any other code leaves the secondary field without effect, whatever
   // it holds, so software may stage it ahead of the primary write
   always_comb begin
      if (pri_code == PRI_DEFER) begin // [RULE1] [RULE2]
         next_stage = sec_stage;
         next_ratio = sec_ratio;
         next_valid = sec_valid;
      end else begin // [RULE2]
         next_stage = pri_stage;
         next_ratio = pri_ratio;
         next_valid = pri_valid;
      end
   end

   // outputs hold the last valid cascade, so a reserved code changes nothing;
   // the chain never sees a half-decoded setting, at the cost of one cycle
   // reset leaves half-band one alone with conversion off, a ratio of two
   always_ff @(posedge sys_clk_in) begin
      if (!rst_b_in) begin
         stage_enable_out <= STG_HALF1;
         decimation_ratio_out <= {RATIO_HALF1[5:0], 1'b0};
         complex_to_real_out <= 1'b0;
      end else if (next_valid) begin // [RULE11]
         stage_enable_out <= next_stage;
         complex_to_real_out <= c2r;
         // disabled conversion doubles the ratio [RULE3] [RULE7]
         decimation_ratio_out <= c2r ? next_ratio : {next_ratio[5:0], 1'b0};
      end
   end
endmodule : ddc_rate_select

// ===== ddc_rate_select_assertions.sv
/* checker for ddc_rate_select: bus answer timing and stage-to-ratio decode.
   bound onto the design ports from the tb file. */
`timescale 1ns/1ps
module ddc_rate_select_chk import ddc_pkg::*; (
   // ports watched
   input wire logic sys_clk_in, rst_b_in, avs_read_in, avs_write_in,
   input wire logic avs_waitrequest_out, complex_to_real_out,
   input wire logic [5:0] stage_enable_out,
   input wire logic [6:0] decimation_ratio_out
);
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (!rst_b_in);
   // exactly one wait state, then back high
   chk_one_wait: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out
      |=> !avs_waitrequest_out ##1 avs_waitrequest_out) else $error("bad wait");
   // chain only moves after a write
   chk_hold_idle: assert property (
      !$past(avs_write_in) && !$past(avs_write_in, 2) |-> $stable(stage_enable_out))
      else $error("chain moved");
   // ratio follows the cascade and the conversion bit
   chk_ratio_third_all: assert property (stage_enable_out == STG_THIRD_HALF4321 |->
      decimation_ratio_out == (complex_to_real_out ? 7'h18 : 7'h30)) else $error("ratio");
   chk_ratio_fifth_one: assert property (stage_enable_out == STG_FIFTH_HALF1 |->
      decimation_ratio_out == (complex_to_real_out ? 7'h05 : 7'h0A)) else $error("ratio");
   chk_ratio_fifth_two: assert property (stage_enable_out == STG_FIFTH_HALF21 |->
      decimation_ratio_out == (complex_to_real_out ? 7'h0A : 7'h14)) else $error("ratio");
   chk_ratio_fifth_three: assert property (stage_enable_out == STG_FIFTH_HALF321 |->
      complex_to_real_out || decimation_ratio_out == 7'h28) else $error("ratio");
   chk_ratio_half_three: assert property (stage_enable_out == STG_HALF123_THIRD |->
      decimation_ratio_out == (complex_to_real_out ? 7'h0C : 7'h18)) else $error("ratio");
   chk_ratio_half_two: assert property (stage_enable_out == STG_HALF12_THIRD |->
      !complex_to_real_out || decimation_ratio_out == 7'h06) else $error("ratio");
endmodule : ddc_rate_select_chk

// ===== tb.sv
/* self-checking bench for ddc_rate_select; the bench is the bus master.
   assumes one clock and the checker file compiled first. */
`timescale 1ns/1ps
module tb;
   import ddc_pkg::*;
   logic clk = 0, rst_b = 0, rd = 0, wr = 0, wreq, c2r;
   logic [13:0] addr = 0;
   logic [31:0] wd = 0, rdata, q;
   logic [5:0] stg;
   logic [6:0] ratio;
   int n_errors = 0, compares = 0, cyc = 0;
   ddc_rate_select i_ddc_rate_select (.sys_clk_in(clk), .rst_b_in(rst_b), .avs_address_in(addr),
      .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd), .avs_byteenable_in(4'hF),
      .avs_readdata_out(rdata), .avs_waitrequest_out(wreq), .stage_enable_out(stg),
      .decimation_ratio_out(ratio), .complex_to_real_out(c2r));
   initial forever #10 clk = ~clk;
   task stop_test();
      $display("errors %0d compares %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : stop_test
   // hang guard, runs well past the expected length
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         n_errors++;
         stop_test();
      end
   end
   task chk(input logic [31:0] g, input logic [31:0] e);
      compares++;
      if (g !== e) begin
         n_errors++;
         $display("unexpected at %0t: %h not %h", $time, g, e);
      end
   endtask : chk
   // one bus cycle, held until waitrequest is seen low
   task bus(input logic w, input logic [13:0] a, input logic [31:0] d);
      @(posedge clk);
      rd <= !w; wr <= w; addr <= a; wd <= d;
      do @(posedge clk); while (wreq !== 1'b0);
      q = rdata;
      rd <= 0; wr <= 0;
   endtask : bus
   // secondary first so a stale code never decodes
   task cfg(input logic [2:0] p, input logic c, input logic [2:0] s, input logic [5:0] st,
      input logic [6:0] r);
      bus(1, SECONDARY_SELECT_ADDR, {s, 4'h0});
      bus(1, PRIMARY_SELECT_ADDR, {c, p});
      repeat (3) @(posedge clk);
      chk(stg, st);
      chk(ratio, c ? r >> 1 : r);
      chk(c2r, c);
   endtask : cfg
   task t_primary();
      cfg(3'h4, 1, 3'h0, 6'h11, 7'h06);
      cfg(3'h3, 0, 3'h0, 6'h01, 7'h02);
      cfg(3'h6, 0, 3'h3, 6'h17, 7'h18);
      cfg(3'h6, 1, 3'h2, 6'h17, 7'h18);
      cfg(3'h5, 1, 3'h4, 6'h13, 7'h0C);
      cfg(3'h0, 1, 3'h4, 6'h13, 7'h0C);
   endtask : t_primary
   task t_second();
      for (int c = 0; c < 2; c++) begin
         cfg(3'h7, c[0], 3'h0, 6'h1F, 7'h30);
         cfg(3'h7, c[0], 3'h2, 6'h21, 7'h0A);
         cfg(3'h7, c[0], 3'h3, 6'h23, 7'h14);
         cfg(3'h7, c[0], 3'h4, 6'h27, 7'h28);
      end
   endtask : t_second
   // reserved code keeps the chain; readback and a hole in the map
   task t_reserved();
      cfg(3'h7, 1, 3'h1, 6'h27, 7'h28);
      bus(0, SECONDARY_SELECT_ADDR, 0);
      chk(q, 32'h10);
      bus(0, 14'h0000, 0);
      chk(q, 32'h0);
      bus(0, STATUS_ADDR, 0);
      chk(q, 32'h6714);
   endtask : t_reserved
   initial begin
      repeat (12) @(posedge clk);
      rst_b <= 1;
      @(posedge clk);
      chk({c2r, ratio, stg}, {1'b0, 7'h02, 6'h01});
      t_primary();
      t_second();
      t_reserved();
      stop_test();
   end
endmodule : tb
bind ddc_rate_select ddc_rate_select_chk i_ddc_rate_select_chk (.sys_clk_in(sys_clk_in),
   .rst_b_in(rst_b_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
   .avs_waitrequest_out(avs_waitrequest_out), .complex_to_real_out(complex_to_real_out),
   .stage_enable_out(stage_enable_out), .decimation_ratio_out(decimation_ratio_out));
